// file: logic/lowest_req_pick.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Lowest-index request picker
// ----------------------------------------
module lowest_req_pick #(
  parameter int N = 20,
  parameter int W = 5
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);

  // Scan from the top so the lowest index wins
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule

`default_nettype wire

// file: logic/reset_irq_vector_gen.sv
`timescale 1ns/1ps
`default_nettype none

module reset_irq_vector_gen (
  input wire logic clk,
  input wire logic arst_n,
  // Fuse levels, from outside the clock domain
  input wire logic boot_reset_select_fuse,
  input wire logic [1:0] boot_size_fuses,
  // Peripheral requests, index 0 is vector 2
  input wire logic [19:0] irq_req,
  // Status register global enable flag
  input wire logic global_irq_enable,
  // One-cycle control register write
  input wire logic ctrl_wr,
  input wire logic ctrl_wr_unlock,
  input wire logic ctrl_wr_select,
  // One-cycle pulse when the core retires an instruction
  input wire logic instr_done,
  // Outputs to the core fetch logic
  output logic [13:0] reset_vector_addr,
  output logic irq_pending,
  output logic [4:0] irq_vector_num,
  output logic [13:0] irq_vector_addr,
  output logic vector_table_select,
  output logic vector_change_unlock,
  output logic irq_suppressed
);

  // ----------------------------------------
  // Fuse synchronisers
  // ----------------------------------------
  logic [2:0] fsel_s1_q, fsel_s2_q, fsel_s3_q;
  logic [2:0] fsel_s1_d, fsel_s2_d, fsel_s3_d;
  logic fuse_rsel_q, fuse_rsel_d;
  logic [1:0] fuse_bsz_q, fuse_bsz_d;

  // Three stages; a change counts once stages two and three agree
  always_comb begin
    fsel_s1_d = {boot_reset_select_fuse, boot_size_fuses};
    fsel_s2_d = fsel_s1_q;
    fsel_s3_d = fsel_s2_q;
    fuse_rsel_d = fuse_rsel_q;
    fuse_bsz_d = fuse_bsz_q;
    if (fsel_s2_q == fsel_s3_q) begin
      fuse_rsel_d = fsel_s3_q[2];
      fuse_bsz_d = fsel_s3_q[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fsel_s1_q <= {vector_gen_pkg::FUSE_RST_RESET_SEL, vector_gen_pkg::FUSE_RST_BOOT_SIZE};
      fsel_s2_q <= {vector_gen_pkg::FUSE_RST_RESET_SEL, vector_gen_pkg::FUSE_RST_BOOT_SIZE};
      fsel_s3_q <= {vector_gen_pkg::FUSE_RST_RESET_SEL, vector_gen_pkg::FUSE_RST_BOOT_SIZE};
      fuse_rsel_q <= vector_gen_pkg::FUSE_RST_RESET_SEL;
      fuse_bsz_q <= vector_gen_pkg::FUSE_RST_BOOT_SIZE;
    end else begin
      fsel_s1_q <= fsel_s1_d;
      fsel_s2_q <= fsel_s2_d;
      fsel_s3_q <= fsel_s3_d;
      fuse_rsel_q <= fuse_rsel_d;
      fuse_bsz_q <= fuse_bsz_d;
    end
  end

  // ----------------------------------------
  // Placement decode
  // ----------------------------------------
  logic [13:0] boot_start;
  logic [13:0] reset_addr_d, reset_addr_q;
  logic [13:0] table_base;
  logic sel_q, sel_d;

  // Boot section start from the size fuses
  always_comb begin
    case (fuse_bsz_q)
      2'h0: boot_start = vector_gen_pkg::BOOT_START_00;
      2'h1: boot_start = vector_gen_pkg::BOOT_START_01;
      2'h2: boot_start = vector_gen_pkg::BOOT_START_10;
      default: boot_start = vector_gen_pkg::BOOT_START_11;
    endcase
  end

  // Fuse and select act independently
  always_comb begin
    // Fuse 1 is unprogrammed: start at zero
    reset_addr_d = fuse_rsel_q ? vector_gen_pkg::RESET_ADDR : boot_start;
    // Vector table base follows the select bit and the size fuses, not the reset fuse
    table_base = sel_q ? boot_start : vector_gen_pkg::RESET_ADDR;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_addr_q <= vector_gen_pkg::RESET_ADDR;
    end else begin
      reset_addr_q <= reset_addr_d;
    end
  end

  // ----------------------------------------
  // Vector relocation sequence
  // ----------------------------------------
  vector_gen_pkg::seq_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic unlock_q, unlock_d;
  logic supp_q, supp_d;
  logic select_write;

  // A write with unlock clear while the window is open
  assign select_write = ctrl_wr && !ctrl_wr_unlock && unlock_q;

  // Unlock window, select update and dispatch hold
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    unlock_d = unlock_q;
    case (state_q)
      vector_gen_pkg::ST_IDLE: begin
        if (ctrl_wr && ctrl_wr_unlock) begin
          state_d = vector_gen_pkg::ST_OPEN;
          cnt_d = vector_gen_pkg::UNLOCK_CYCLES;
          unlock_d = 1'b1;
        end
      end
      vector_gen_pkg::ST_OPEN: begin
        if (select_write) begin
          sel_d = ctrl_wr_select;
          unlock_d = 1'b0;
          state_d = vector_gen_pkg::ST_HOLD;
        end else if (ctrl_wr && ctrl_wr_unlock) begin
          // Rewriting the unlock restarts the window
          cnt_d = vector_gen_pkg::UNLOCK_CYCLES;
        end else if (cnt_q == 3'h1) begin
          unlock_d = 1'b0;
          state_d = vector_gen_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      vector_gen_pkg::ST_HOLD: begin
        // A fresh unlock reopens the window; else wait for retire
        if (ctrl_wr && ctrl_wr_unlock) begin
          state_d = vector_gen_pkg::ST_OPEN;
          cnt_d = vector_gen_pkg::UNLOCK_CYCLES;
          unlock_d = 1'b1;
        end else if (instr_done) begin
          state_d = vector_gen_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = vector_gen_pkg::ST_IDLE;
        unlock_d = 1'b0;
      end
    endcase
    // Held from the unlock write cycle; global enable untouched
    supp_d = (state_d != vector_gen_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= vector_gen_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      sel_q <= vector_gen_pkg::SELECT_RST;
      unlock_q <= 1'b0;
      supp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      unlock_q <= unlock_d;
      supp_q <= supp_d;
    end
  end

  // ----------------------------------------
  // Request selection and vector address
  // ----------------------------------------
  logic req_any;
  logic [4:0] req_idx;
  logic pend_d, pend_q;
  logic [4:0] vnum_d, vnum_q;
  logic [13:0] vaddr_d, vaddr_q;
  logic block_now;

  // Lowest vector number wins
  lowest_req_pick #(
    .N(vector_gen_pkg::NUM_SRC),
    .W(vector_gen_pkg::VNUM_W)
  ) u_pick (
    .req(irq_req),
    .any(req_any),
    .idx(req_idx)
  );

  // Blocked in the unlock write cycle as well
  assign block_now = supp_d || (ctrl_wr && ctrl_wr_unlock);

  // Address is table base plus two times (vector number minus one)
  always_comb begin
    vnum_d = req_idx + vector_gen_pkg::FIRST_IRQ_VEC;
    // Source index i gives slot 2*(i+1): 002 for request 0, 028 for index 19
    vaddr_d = table_base + 14'(vnum_d - 5'h01) * vector_gen_pkg::VEC_SPACING;
    pend_d = req_any && global_irq_enable && !block_now;
    if (!pend_d) begin
      vnum_d = 5'h00;
      vaddr_d = table_base;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      vnum_q <= 5'h00;
      vaddr_q <= vector_gen_pkg::RESET_ADDR;
    end else begin
      pend_q <= pend_d;
      vnum_q <= vnum_d;
      vaddr_q <= vaddr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All outputs come straight from flip-flops
  assign reset_vector_addr = reset_addr_q;
  assign irq_pending = pend_q;
  assign irq_vector_num = vnum_q;
  assign irq_vector_addr = vaddr_q;
  assign vector_table_select = sel_q;
  assign vector_change_unlock = unlock_q;
  assign irq_suppressed = supp_q;

endmodule

`default_nettype wire

// file: pkg/vector_gen_pkg.sv
// ----------------------------------------
// Shared constants for the vector generator
// ----------------------------------------
package vector_gen_pkg;

  // Word address width of program flash
  localparam int ADDR_W = 14;
  // Interrupt sources, vectors 2..21 (vector 1 is reset)
  localparam int NUM_SRC = 20;
  localparam int NUM_VEC = 21;
  localparam int VNUM_W = 5;
  // Vector number held by source index 0
  localparam logic [VNUM_W-1:0] FIRST_IRQ_VEC = 5'h02;
  // Slots are two words apart
  localparam logic [ADDR_W-1:0] VEC_SPACING = 14'h0002;
  // Reset entry with the boot reset fuse unprogrammed
  localparam logic [ADDR_W-1:0] RESET_ADDR = 14'h0000;
  // Boot section start per boot_size_fuses code
  localparam logic [ADDR_W-1:0] BOOT_START_00 = 14'h3800;
  localparam logic [ADDR_W-1:0] BOOT_START_01 = 14'h3C00;
  localparam logic [ADDR_W-1:0] BOOT_START_10 = 14'h3E00;
  localparam logic [ADDR_W-1:0] BOOT_START_11 = 14'h3F00;
  // Reset values of fuse shadows: unprogrammed
  localparam logic FUSE_RST_RESET_SEL = 1'b1;
  localparam logic [1:0] FUSE_RST_BOOT_SIZE = 2'h3;
  // Reset value of the select bit
  localparam logic SELECT_RST = 1'b0;
  // Cycles the unlock stays open
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // Relocation sequence states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPEN = 2'b01,
    ST_HOLD = 2'b10
  } seq_state_t;

endpackage

// file: tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter int LAG = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic kick,
  output logic instr_done
);
  int cnt;
  // Retire pulse a few cycles after each kick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= (cnt == 1);
      cnt <= kick ? LAG : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, arst_n, rsel, en, wr, wu, ws, kick, done, pend, sel, unl, sup;
  logic [1:0] bsize;
  logic [19:0] req;
  logic [4:0] vnum;
  logic [13:0] rva, vaddr;
  int bad_count = 0;
  int total_checks = 0;
  reset_irq_vector_gen i_dut (.clk(clk), .arst_n(arst_n), .boot_reset_select_fuse(rsel),
    .boot_size_fuses(bsize), .irq_req(req), .global_irq_enable(en), .ctrl_wr(wr),
    .ctrl_wr_unlock(wu), .ctrl_wr_select(ws), .instr_done(done), .reset_vector_addr(rva),
    .irq_pending(pend), .irq_vector_num(vnum), .irq_vector_addr(vaddr),
    .vector_table_select(sel), .vector_change_unlock(unl), .irq_suppressed(sup));
  core_model i_core (.clk(clk), .arst_n(arst_n), .kick(kick), .instr_done(done));
  // ----------------
  // Helpers
  // ----------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  function automatic logic [4:0] low_num(input logic [19:0] r);
    for (int i = 0; i < 20; i++) if (r[i]) return 5'(i + 2);
    return 5'h00;
  endfunction
  function automatic logic [13:0] boot_of(input logic [1:0] s);
    return s == 2'h0 ? 14'h3800 : s == 2'h1 ? 14'h3C00 : s == 2'h2 ? 14'h3E00 : 14'h3F00;
  endfunction
  task automatic try_req(input logic [19:0] r, input logic [13:0] base);
    logic [4:0] n;
    req = r;
    cyc(1);
    n = (en && r != 20'h00000) ? low_num(r) : 5'h00;
    check(pend, n != 5'h00);
    check(vnum, n);
    check(vaddr, n != 5'h00 ? base + {n - 5'h01, 1'b0} : base);
  endtask
  task automatic ctl(input logic u, input logic s);
    wr = 1'b1;
    wu = u;
    ws = s;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------
  // Clock and watchdog
  // ----------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #75000;
    bad_count++;
    give_verdict();
  end
  // ----------------
  // Tests
  // ----------------
  initial begin
    {rsel, bsize, req, en, wr, wu, ws, kick, arst_n} = {3'h7, 20'h00000, 6'h20};
    void'($urandom(32'hff0180db));
    cyc(2);
    arst_n = 1'b1;
    cyc(6);
    check(sel, 1'b0);
    check(rva, 14'h0000);
    for (int i = 0; i < 20; i++) try_req(20'h00001 << i, 14'h0000);
    $display("single sources done");
    try_req(20'hFFFFF, 14'h0000);
    repeat (30) begin
      en = ($urandom % 4) != 0;
      try_req(20'($urandom), 14'h0000);
    end
    en = 1'b1;
    req = 20'h00001;
    $display("random priority done");
    ctl(1'b0, 1'b1);
    cyc(1);
    check(sel, 1'b0);
    ctl(1'b1, 1'b0);
    check({unl, sup, pend}, 3'h6);
    cyc(3);
    check(unl, 1'b1);
    cyc(1);
    check({unl, sup, pend}, 3'h1);
    $display("unlock timeout done");
    req = 20'h00000;
    ctl(1'b1, 1'b0);
    cyc(1);
    ctl(1'b0, 1'b1);
    check({sel, unl, sup}, 3'h5);
    kick = 1'b1;
    cyc(1);
    kick = 1'b0;
    cyc(3);
    check(sup, 1'b1);
    cyc(2);
    check(sup, 1'b0);
    for (int k = 0; k < 8; k++) begin
      {rsel, bsize} = 3'(k);
      cyc(6);
      check(rva, rsel ? 14'h0000 : boot_of(bsize));
      try_req(20'($urandom) | 20'h80000, boot_of(bsize));
    end
    $display("relocation done");
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(1);
    check(sel, 1'b0);
    check(rva, 14'h0000);
    $display("second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire

// file: tb/vec_gen_props.sv
`timescale 1ns/1ps
`default_nettype none
module vec_gen_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [19:0] irq_req,
  input wire logic global_irq_enable,
  input wire logic ctrl_wr,
  input wire logic ctrl_wr_unlock,
  input wire logic ctrl_wr_select,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic [4:0] irq_vector_num,
  input wire logic [13:0] irq_vector_addr,
  input wire logic vector_table_select,
  input wire logic vector_change_unlock,
  input wire logic irq_suppressed
);
  // ----------------
  // Dispatch checks
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_addr_of_num: assert property (irq_pending && !vector_table_select |->
    irq_vector_addr == {irq_vector_num - 5'h01, 1'b0}) else $error("vector address off");
  a_lowest_wins: assert property (irq_pending |->
    ($past(irq_req) & (~$past(irq_req) + 20'h00001)) == (20'h00001 << (irq_vector_num - 5'h02)))
    else $error("not the lowest request");
  a_enable_gate: assert property (!$past(global_irq_enable) |-> !irq_pending)
    else $error("pending while disabled");
  a_suppress_blocks: assert property (irq_suppressed |-> !irq_pending)
    else $error("pending while suppressed");
  // ----------------
  // Change sequence
  // ----------------
  a_unlock_open: assert property (ctrl_wr && ctrl_wr_unlock |=>
    vector_change_unlock && irq_suppressed && !irq_pending) else $error("unlock not opened");
  a_unlock_expire: assert property (($rose(vector_change_unlock) && !ctrl_wr) ##1 !ctrl_wr [*3]
    |=> !vector_change_unlock && !irq_suppressed) else $error("unlock not expired");
  a_locked_ignore: assert property (ctrl_wr && !vector_change_unlock && !ctrl_wr_unlock
    |=> $stable(vector_table_select)) else $error("select changed while locked");
  a_select_write: assert property (ctrl_wr && vector_change_unlock && !ctrl_wr_unlock |=>
    vector_table_select == $past(ctrl_wr_select) && !vector_change_unlock) else $error("select write");
  a_hold_keep: assert property (irq_suppressed && !vector_change_unlock && !instr_done
    |=> irq_suppressed) else $error("hold ended early");
  a_hold_release: assert property (irq_suppressed && !vector_change_unlock && instr_done
    && !ctrl_wr |=> !irq_suppressed) else $error("hold not released");
  c_moved_pend: cover property (irq_pending && vector_table_select);
  c_moved: cover property ($rose(vector_table_select));
  c_expired: cover property ($fell(vector_change_unlock) && !irq_suppressed);
endmodule
bind reset_irq_vector_gen vec_gen_props i_props (.*);
`default_nettype wire
